// *** verilog/sofm_pkg.sv ***
//------------------------------------------------------------
// constants for the safety output field monitor
//------------------------------------------------------------
package sofm_pkg;
    localparam int unsigned DELAY_W = 8;
    localparam logic [DELAY_W-1:0] RESTART_DELAY_DEF = 8'h00;
    localparam int unsigned BLINK_DIV = 5000000;
    localparam int unsigned BLINK_W = 23;
    localparam logic [BLINK_W-1:0] BLINK_LAST = 23'h4c4b3f;
    localparam logic [BLINK_W-1:0] BLINK_ZERO = 23'h000000;
    localparam logic [DELAY_W-1:0] DELAY_ZERO = 8'h00;
    localparam logic [DELAY_W-1:0] DELAY_ONE = 8'h01;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_SEEN = 3'b010,
        ST_RUN = 3'b100
    } sofm_state_t;
endpackage : sofm_pkg

// *** verilog/sofm_chan_if.sv ***
//------------------------------------------------------------
// per-channel link between top and channel logic
//------------------------------------------------------------
interface sofm_chan_if;
    import sofm_pkg::*;
    logic run;
    logic prot;
    logic warn;
    logic cycle_tick;
    logic [DELAY_W-1:0] delay;
    logic closed;
    logic signal_on;
    modport top (output run, prot, warn, cycle_tick, delay,
                 input closed, signal_on);
    modport chan (input run, prot, warn, cycle_tick, delay,
                  output closed, signal_on);
endinterface : sofm_chan_if

// *** verilog/sofm_chan.sv ***
//------------------------------------------------------------
// one sensor channel: safe output pair and signal output
//------------------------------------------------------------
module sofm_chan
(
    input wire logic core_clk,
    input wire logic srst,
    sofm_chan_if.chan ch
);
    import sofm_pkg::*;

    logic closed_q, closed_d;
    logic sig_q, sig_d;
    logic [DELAY_W-1:0] cnt_q, cnt_d;

    // protection intrusion opens at once; reclose waits the delay
    always_comb
    begin
        closed_d = closed_q;
        cnt_d = cnt_q;
        // warning zones count only once running; the test shows protection
        sig_d = ch.prot | (ch.run & ch.warn);
        if (!ch.run)
        begin
            closed_d = 1'b0;
            cnt_d = DELAY_ZERO;
        end
        else if (ch.prot)
        begin
            closed_d = 1'b0;
            cnt_d = DELAY_ZERO;
        end
        else if (!closed_q)
        begin
            // delay counts measurement cycles, zero recloses at once
            if (cnt_q >= ch.delay)
                closed_d = 1'b1;
            else if (ch.cycle_tick)
                cnt_d = cnt_q + DELAY_ONE;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            closed_q <= 1'b0;
            sig_q <= 1'b0;
            cnt_q <= DELAY_ZERO;
        end
        else
        begin
            closed_q <= closed_d;
            sig_q <= sig_d;
            cnt_q <= cnt_d;
        end
    end

    assign ch.closed = closed_q;
    assign ch.signal_on = sig_q;
endmodule : sofm_chan

// *** verilog/sofm_top.sv ***
//------------------------------------------------------------
// decision logic of the two-channel field monitor
//------------------------------------------------------------
module sofm_top
#(
    parameter logic [sofm_pkg::DELAY_W-1:0] RESTART_DELAY =
        sofm_pkg::RESTART_DELAY_DEF,
    parameter logic [sofm_pkg::BLINK_W-1:0] BLINK_END =
        sofm_pkg::BLINK_LAST
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cycle_tick,
    input wire logic skip_start_test,
    input wire logic [sofm_pkg::DELAY_W-1:0] restart_delay,
    input wire logic prot_zone_1,
    input wire logic warn_zone_1,
    input wire logic prot_zone_2,
    input wire logic warn_zone_2,
    output logic safe_out_ch1_a,
    output logic safe_out_ch1_b,
    output logic safe_out_ch2_a,
    output logic safe_out_ch2_b,
    output logic led_ch1_green,
    output logic led_ch2_green,
    output logic signal_out_1,
    output logic signal_out_2,
    output logic led_power
);
    import sofm_pkg::*;

    //--------------------------------------------------------
    // local state
    //--------------------------------------------------------
    // interlock state, one-hot
    sofm_state_t state_q, state_d;
    // blink divider count and lamp level
    logic [BLINK_W-1:0] blink_q, blink_d;
    logic blink_lvl_q, blink_lvl_d;
    logic blink_wrap;
    // registered power lamp
    logic power_q, power_d;
    // restart delay as the channels apply it
    logic [DELAY_W-1:0] delay_q, delay_d;
    // decoded interlock conditions
    logic any_prot;
    logic run;

    // per-channel carriers
    sofm_chan_if ch1 ();
    sofm_chan_if ch2 ();

    // either sensor may carry the test object
    assign any_prot = prot_zone_1 | prot_zone_2;
    // only the run state lets the channels close
    assign run = (state_q == ST_RUN);

    //--------------------------------------------------------
    // start interlock
    //--------------------------------------------------------
    // test passes when object seen, then zones clear again
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_WAIT:
            begin
                // a stored setting may waive the test entirely
                if (skip_start_test)
                    state_d = ST_RUN;
                else if (any_prot)
                    state_d = ST_SEEN;
            end
            ST_SEEN:
            begin
                // release only once the zones are empty again
                if (!any_prot)
                    state_d = ST_RUN;
            end
            ST_RUN: state_d = ST_RUN;
            // any stray code falls back to the safe wait state
            default: state_d = ST_WAIT;
        endcase
    end

    // only reset leaves run; no zone event reopens the interlock
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q <= ST_WAIT;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    //--------------------------------------------------------
    // blink divider
    //--------------------------------------------------------
    // one-cycle wrap enable toggles the lamp level
    assign blink_wrap = (blink_q >= BLINK_END);

    always_comb
    begin
        blink_d = blink_q + {{(BLINK_W-1){1'b0}}, 1'b1};
        blink_lvl_d = blink_lvl_q;
        // wrap restarts the count and flips the level
        if (blink_wrap)
        begin
            blink_d = BLINK_ZERO;
            blink_lvl_d = ~blink_lvl_q;
        end
    end

    // divider runs freely; only the wait state shows its level
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            blink_q <= BLINK_ZERO;
            blink_lvl_q <= 1'b0;
        end
        else
        begin
            blink_q <= blink_d;
            blink_lvl_q <= blink_lvl_d;
        end
    end

    //--------------------------------------------------------
    // power lamp
    //--------------------------------------------------------
    // blinking while waiting, steady once the object is seen
    always_comb
    begin
        case (state_q)
            ST_WAIT: power_d = blink_lvl_q;
            ST_SEEN: power_d = 1'b1;
            ST_RUN: power_d = 1'b1;
            // stray codes leave the lamp dark
            default: power_d = 1'b0;
        endcase
    end

    // lamp is dark during reset
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            power_q <= 1'b0;
        end
        else
        begin
            power_q <= power_d;
        end
    end

    //--------------------------------------------------------
    // restart delay setting
    //--------------------------------------------------------
    // registered copy keeps the setting lines off the reclose
    // compare; a change takes effect one cycle later
    always_comb
    begin
        // no qualification: the setting is a plain level
        delay_d = restart_delay;
    end

    // reset applies the default delay until the first edge
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            delay_q <= RESTART_DELAY;
        end
        else
        begin
            delay_q <= delay_d;
        end
    end

    //--------------------------------------------------------
    // channels
    //--------------------------------------------------------
    // both channels share the interlock and restart delay
    // channel 1 wiring
    assign ch1.run = run;
    assign ch1.prot = prot_zone_1;
    assign ch1.warn = warn_zone_1;
    assign ch1.cycle_tick = cycle_tick;
    assign ch1.delay = delay_q;

    // channel 2 wiring
    assign ch2.run = run;
    assign ch2.prot = prot_zone_2;
    assign ch2.warn = warn_zone_2;
    assign ch2.cycle_tick = cycle_tick;
    assign ch2.delay = delay_q;

    // sensor 1 channel
    sofm_chan u_ch1 (.core_clk(core_clk), .srst(srst), .ch(ch1.chan));
    // sensor 2 channel
    sofm_chan u_ch2 (.core_clk(core_clk), .srst(srst), .ch(ch2.chan));

    //--------------------------------------------------------
    // outputs
    //--------------------------------------------------------
    // one flop per channel drives both outputs and the lamp
    assign safe_out_ch1_a = ch1.closed;
    assign safe_out_ch1_b = ch1.closed;
    assign safe_out_ch2_a = ch2.closed;
    assign safe_out_ch2_b = ch2.closed;
    assign led_ch1_green = ch1.closed;
    assign led_ch2_green = ch2.closed;

    // signal flops sit in the channels, in step with the outputs
    assign signal_out_1 = ch1.signal_on;
    assign signal_out_2 = ch2.signal_on;
    assign led_power = power_q;
endmodule : sofm_top

// *** bench/sofm_properties.sv ***
// ---
// output relation checks
// ---
module sofm_properties
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [sofm_pkg::DELAY_W-1:0] restart_delay,
    input wire logic prot_zone_1,
    input wire logic warn_zone_1,
    input wire logic prot_zone_2,
    input wire logic safe_out_ch1_a,
    input wire logic safe_out_ch1_b,
    input wire logic safe_out_ch2_a,
    input wire logic safe_out_ch2_b,
    input wire logic led_ch1_green,
    input wire logic signal_out_1,
    input wire logic led_power
);
    timeunit 1ns;
    timeprecision 1ns;
    logic run_q;
    // set once any channel closed; stays until reset
    always_ff @(posedge core_clk)
        run_q <= srst ? 1'b0 : (run_q | safe_out_ch1_a | safe_out_ch2_a);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    chk_pair_one: assert property (safe_out_ch1_b == safe_out_ch1_a &&
        led_ch1_green == safe_out_ch1_a) else $error("channel 1 split");
    chk_pair_two: assert property (safe_out_ch2_b == safe_out_ch2_a)
        else $error("channel 2 split");
    chk_reset_open: assert property ($past(srst) |->
        !(safe_out_ch1_a | safe_out_ch2_a)) else $error("closed at start");
    chk_prot_one: assert property (prot_zone_1 |=> !safe_out_ch1_a)
        else $error("channel 1 not opened");
    chk_prot_two: assert property (prot_zone_2 |=> !safe_out_ch2_a)
        else $error("channel 2 not opened");
    chk_warn_keep: assert property (safe_out_ch1_a && !prot_zone_1 |=>
        safe_out_ch1_a) else $error("channel 1 dropped");
    chk_sig_one: assert property (safe_out_ch1_a && warn_zone_1 |=>
        signal_out_1) else $error("signal 1 missing");
    chk_reclose: assert property (run_q && restart_delay == 8'h00 &&
        !prot_zone_2 |=> safe_out_ch2_a) else $error("no reclose");
    chk_power_run: assert property (run_q |-> led_power)
        else $error("power lamp off");
endmodule : sofm_properties

bind sofm_top sofm_properties chk (.core_clk, .srst, .restart_delay,
    .prot_zone_1, .warn_zone_1, .prot_zone_2, .safe_out_ch1_a,
    .safe_out_ch1_b, .safe_out_ch2_a, .safe_out_ch2_b, .led_ch1_green,
    .signal_out_1, .led_power);

// *** bench/sofm_machine.sv ***
// ---
// machine side safety circuit
// ---
module sofm_machine
(
    input wire logic core_clk,
    input wire logic [3:0] safe_outs,
    output logic may_run_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // machine may move only with every contact closed
    always_ff @(posedge core_clk)
        may_run_q <= &safe_outs;
endmodule : sofm_machine

// *** bench/sofm_tb_top.sv ***
// ---
// field monitor bench
// ---
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %0t value mismatch", $time); end end
module sofm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, srst = 1'b1, cycle_tick = 1'b0;
    logic skip_start_test = 1'b0, prot_zone_1 = 1'b0, warn_zone_1 = 1'b0;
    logic prot_zone_2 = 1'b0, warn_zone_2 = 1'b0, prev, may_run_q;
    logic [7:0] restart_delay = 8'h00, e;
    logic [31:0] lfsr_q = 32'hdaa7;
    logic safe_out_ch1_a, safe_out_ch1_b, safe_out_ch2_a, safe_out_ch2_b;
    logic led_ch1_green, led_ch2_green, signal_out_1, signal_out_2, led_power;
    int miscompares = 0, num_checks = 0, i, t;
    wire [7:0] obs = {safe_out_ch1_a, safe_out_ch1_b, led_ch1_green,
        safe_out_ch2_a, safe_out_ch2_b, led_ch2_green, signal_out_1,
        signal_out_2};
    sofm_top #(.RESTART_DELAY(8'h00), .BLINK_END(23'h000003)) dut (.core_clk,
        .srst, .cycle_tick, .skip_start_test, .restart_delay, .prot_zone_1,
        .warn_zone_1, .prot_zone_2, .warn_zone_2, .safe_out_ch1_a,
        .safe_out_ch1_b, .safe_out_ch2_a, .safe_out_ch2_b, .led_ch1_green,
        .led_ch2_green, .signal_out_1, .signal_out_2, .led_power);
    sofm_machine machine (.core_clk, .may_run_q, .safe_outs({safe_out_ch1_a,
        safe_out_ch1_b, safe_out_ch2_a, safe_out_ch2_b}));
    function logic [7:0] exp_obs(input logic p1, w1, p2, w2);
        return {{3{!p1}}, {3{!p2}}, p1 | w1, p2 | w2};
    endfunction : exp_obs
    function logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task zones(input logic [3:0] z);
        @(posedge core_clk);
        {prot_zone_1, warn_zone_1, prot_zone_2, warn_zone_2} <= z;
    endtask : zones
    task end_sim;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    // free running 10 MHz clock
    initial forever #50 core_clk = ~core_clk;
    // hang guard, far beyond the expected run
    initial
    begin
        #200000;
        miscompares++;
        end_sim;
    end
    // main sequence
    initial
    begin
        tick(4);
        srst <= 1'b0;
        t = 0;
        prev = 1'b0;
        repeat (24)
        begin
            @(negedge core_clk);
            `CHK(obs, 8'h00)
            t += int'(led_power !== prev);
            prev = led_power;
        end
        `CHK(t >= 4, 1'b1)
        zones(4'b1000);
        tick(2);
        repeat (6)
        begin
            @(negedge core_clk);
            `CHK({signal_out_1, led_power, safe_out_ch1_a}, 3'b110)
        end
        zones(4'b0000);
        tick(3);
        @(negedge core_clk);
        `CHK(obs, exp_obs(0, 0, 0, 0))
        `CHK({may_run_q, led_power}, 2'b11)
        // each zone alone, then clear again
        for (i = 0; i < 4; i++)
        begin
            zones(4'b0001 << i);
            tick(1);
            @(negedge core_clk);
            `CHK(obs, exp_obs(i == 3, i == 2, i == 1, i == 0))
            zones(4'b0000);
            tick(1);
            @(negedge core_clk);
            `CHK(obs, exp_obs(0, 0, 0, 0))
        end
        zones(4'b1000);
        restart_delay <= 8'h03;
        zones(4'b0000);
        // third measurement cycle after clearing recloses the channel
        for (i = 0; i < 4; i++)
        begin
            @(posedge core_clk) cycle_tick <= 1'b1;
            @(posedge core_clk) cycle_tick <= 1'b0;
            tick(2);
            @(negedge core_clk);
            `CHK(safe_out_ch1_a, i >= 2)
        end
        @(posedge core_clk) restart_delay <= 8'h00;
        // random zone traffic, expectation from inputs seen at each edge
        repeat (300)
        begin
            @(posedge core_clk);
            e = exp_obs(prot_zone_1, warn_zone_1, prot_zone_2, warn_zone_2);
            lfsr_q = lfsr_next(lfsr_q);
            {prot_zone_1, warn_zone_1, prot_zone_2, warn_zone_2,
                cycle_tick} <= lfsr_q[4:0];
            @(negedge core_clk);
            `CHK(obs, e)
        end
        zones(4'b0000);
        srst <= 1'b1;
        skip_start_test <= 1'b1;
        cycle_tick <= 1'b0;
        tick(4);
        srst <= 1'b0;
        tick(3);
        @(negedge core_clk);
        `CHK(obs, exp_obs(0, 0, 0, 0))
        end_sim;
    end
endmodule : sofm_tb_top
